// ---- logic/lrp_pkg.sv ----
// shared constants and types of the local request port
package lrp_pkg;
	// -------------------------------------------------------------
	// widths and address layout
	// -------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 64;
	localparam int BE_W = DATA_W / 8;
	localparam int BANK_W = 3;
	localparam int ROW_W = 13;
	localparam int COL_W = 8;
	localparam int RK_W = ADDR_W - COL_W;
	localparam int MA_W = 13;
	localparam int Q_DEPTH = 4;
	localparam int QP_W = 2;
	localparam int QC_W = 3;
	localparam int WAIT_W = 8;
	localparam int REFI_W = 9;
	localparam logic [QC_W-1:0] QC_FULL = 3'h4;
	localparam logic [QC_W-1:0] QC_ZERO = 3'h0;
	localparam logic [QP_W-1:0] QP_ONE = 2'h1;
	localparam logic [1:0] SIZE_TWO = 2'h2;
	localparam logic [3:0] MEM_BL4 = 4'h4;
	localparam logic [3:0] MEM_BL8 = 4'h8;
	localparam logic [1:0] COL_PAD = 2'h0;
	localparam logic [MA_W-1:0] MA_PRE_ALL = 13'h0400;
	localparam logic [1:0] DV_NONE = 2'h0;
	localparam logic [1:0] DV_BOTH = 2'h3;
	localparam logic [1:0] DQS_PRE = 2'h2;
	localparam logic [BE_W-1:0] MASK_ALL = 8'hff;
	localparam logic CKE_RST = 1'h1;
	// -------------------------------------------------------------
	// memory timing, times in ps, counts in half-rate cycles
	// -------------------------------------------------------------
	localparam int CLK_PS = 25000;
	localparam int T_RCD_PS = 13750;
	localparam int T_RP_PS = 13750;
	localparam int T_RFC_PS = 110000;
	localparam int T_WR_PS = 15000;
	localparam int T_XP_PS = 7500;
	localparam int T_XS_PS = 120000;
	localparam int T_REFI_PS = 7800000;
	localparam int RCD_CYC = (T_RCD_PS + CLK_PS - 1) / CLK_PS;
	localparam int RP_CYC = (T_RP_PS + CLK_PS - 1) / CLK_PS;
	localparam int RFC_CYC = (T_RFC_PS + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC = (T_WR_PS + CLK_PS - 1) / CLK_PS;
	localparam int XP_CYC = (T_XP_PS + CLK_PS - 1) / CLK_PS;
	localparam int XS_CYC = (T_XS_PS + CLK_PS - 1) / CLK_PS;
	localparam int REFI_CYC = T_REFI_PS / CLK_PS;
	localparam int WL_CYC = 2;
	localparam int RL_CYC = 3;
	localparam int W_TOP = WL_CYC + 1;
	localparam int R_TOP = RL_CYC + 1;
	localparam logic [WAIT_W-1:0] WAIT_ONE = 8'h01;
	// -------------------------------------------------------------
	// enumerations and carriers
	// -------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_WR = 4'h2, CMD_RD = 4'h3,
		CMD_PRE = 4'h4, CMD_REF = 4'h5, CMD_PDE = 4'h6, CMD_PDX = 4'h7,
		CMD_SRE = 4'h8, CMD_SRX = 4'h9
	} lrp_cmd_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_ACT = 4'h1, S_CMD = 4'h3, S_PRE = 4'h2,
		S_WAIT = 4'h6, S_REF = 4'h7, S_PDE = 4'h5, S_PD = 4'h4,
		S_PDX = 4'hc, S_SRE = 4'hd, S_SR = 4'hf, S_SRX = 4'he
	} lrp_state_t;
	typedef struct packed {
		logic write_req;
		logic read_req;
		logic burstbegin;
		logic [1:0] size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [BE_W-1:0] user_byte_enables;
	} lrp_user_req_t;
	typedef struct packed {
		logic is_wr;
		logic size2;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data0;
		logic [BE_W-1:0] be0;
		logic [DATA_W-1:0] data1;
		logic [BE_W-1:0] be1;
	} lrp_entry_t;
	typedef struct packed {
		lrp_cmd_t cmd;
		logic [BANK_W-1:0] bank;
		logic [MA_W-1:0] addr;
		logic [3:0] bl;
		logic cke;
	} lrp_phy_cmd_t;
	typedef struct packed {
		logic vld;
		logic [DATA_W-1:0] data;
		logic [BE_W-1:0] be;
	} lrp_wslot_t;
endpackage : lrp_pkg

// ---- logic/lrp_req_queue.sv ----
// four-entry request queue with late fill of the second write beat
`timescale 1ns/10ps
module lrp_req_queue
	import lrp_pkg::*;
(
	input logic clk,
	input logic rst,
	input logic push,
	input lrp_entry_t push_entry,
	input logic beat2_we,
	input logic [DATA_W-1:0] beat2_data,
	input logic [BE_W-1:0] beat2_be,
	input logic pop,
	output lrp_entry_t head,
	output logic [QC_W-1:0] count
);
	lrp_entry_t mem_r [Q_DEPTH];
	lrp_entry_t mem_nxt [Q_DEPTH];
	logic [QP_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [QC_W-1:0] cnt_r, cnt_nxt;

	assign head = mem_r[rp_r];
	assign count = cnt_r;

	always_comb begin
		mem_nxt = mem_r;
		if (push) begin
			mem_nxt[wp_r] = push_entry;
		end
		// second beat lands in the entry pushed one cycle earlier
		if (beat2_we) begin
			mem_nxt[wp_r - QP_ONE].data1 = beat2_data;
			mem_nxt[wp_r - QP_ONE].be1 = beat2_be;
		end
		wp_nxt = wp_r + QP_W'(push);
		rp_nxt = rp_r + QP_W'(pop);
		cnt_nxt = cnt_r + QC_W'(push) - QC_W'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_r <= '{default: '0};
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : lrp_req_queue

// ---- logic/lrp_local_port.sv ----
// local request port of a half-rate ddr3 memory controller
`timescale 1ns/10ps
// Overview of operation
// - one or two local words per request become memory bursts of 4 or 8
// - a request is taken in a cycle with ready high; next may follow
// - word split low half first; byte enables become inverted mask bits
// - up to four requests queued; ready high while room remains, low in a second write beat cycle
// - activation then reads or writes issued in order to the phy
// - strobe and data-valid controls are two bits, one per full-rate clock
// - strobe enabled one full-rate clock before write data
// - write data and mask move with the data-valid control
// - reads are requested like writes and held until taken
// - read-in-progress control marks when and how long to capture
// - read data returned in order, flagged by read-data-valid
// - refresh request beats queued accesses, after the active one ends
// - refresh acknowledge pulses on every refresh command issued
// - request held after acknowledge asks another; drop resumes accesses
// - power-down and self-refresh handshakes; ack means memory is there
// - no refresh and no refresh acknowledge during self-refresh
// - memory timing kept on entry, stay and exit of low power
// - long power-down wakes memory for a refresh with ack pulse
// - stay low power until request drops; ack falls after exit timing
module lrp_local_port
	import lrp_pkg::*;
(
	input logic clk,
	input logic rst,
	input lrp_user_req_t user_req,
	input logic user_refresh_ctl_en,
	input logic user_refresh_req,
	input logic user_powerdown_req,
	input logic user_selfrefresh_req,
	input logic [DATA_W-1:0] phy_rdata,
	input logic phy_rdata_valid,
	output logic user_ready_r,
	output logic [DATA_W-1:0] user_rdata_r,
	output logic user_rdata_valid_r,
	output logic user_refresh_ack_r,
	output logic user_powerdown_ack_r,
	output logic user_selfrefresh_ack_r,
	output lrp_phy_cmd_t phy_cmd_r,
	output logic [DATA_W-1:0] phy_wdata_r,
	output logic [BE_W-1:0] phy_write_mask_r,
	output logic [1:0] phy_wdata_valid_r,
	output logic [1:0] phy_dqs_burst_r,
	output logic [1:0] phy_doing_read_r
);
	// -------------------------------------------------------------
	// address decode helpers
	// -------------------------------------------------------------
	function automatic logic [RK_W-1:0] row_key(
		input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:COL_W];
	endfunction : row_key

	function automatic logic [BANK_W-1:0] bank_of(
		input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: BANK_W];
	endfunction : bank_of

	lrp_state_t st_r, st_nxt, ret_r, ret_nxt;
	logic [WAIT_W-1:0] wait_r, wait_nxt, rec_r, rec_nxt;
	lrp_phy_cmd_t cmd_nxt;
	logic open_r, open_nxt, last_wr_r, last_wr_nxt;
	logic [RK_W-1:0] open_row_r, open_row_nxt;
	logic beat2_r, beat2_nxt, ready_nxt, acc, pop, ins_wr, ins_rd;
	logic ref_ack_nxt, pd_ack_nxt, sr_ack_nxt;
	logic [REFI_W-1:0] refi_r, refi_nxt;
	logic refi_due_r, refi_due_nxt, refresh_due, hit, busy;
	logic [QC_W-1:0] q_count, cnt_nxt;
	lrp_entry_t head, push_entry;
	lrp_wslot_t wp_r [1:W_TOP];
	lrp_wslot_t wp_nxt [1:W_TOP];
	lrp_wslot_t wp_shift [1:W_TOP];
	logic [R_TOP:1] rp_r, rp_nxt;
	logic [DATA_W-1:0] wdata_nxt;
	logic [BE_W-1:0] mask_nxt;
	logic [1:0] wvld_nxt, dqs_nxt, drd_nxt;

	// -------------------------------------------------------------
	// request intake and queue
	// -------------------------------------------------------------
	lrp_req_queue u_queue (
		.clk(clk),
		.rst(rst),
		.push(acc),
		.push_entry(push_entry),
		.beat2_we(beat2_r),
		.beat2_data(user_req.wdata),
		.beat2_be(user_req.user_byte_enables),
		.pop(pop),
		.head(head),
		.count(q_count)
	);

	always_comb begin
		acc = user_ready_r & (user_req.write_req | user_req.read_req);
		push_entry.is_wr = user_req.write_req;
		push_entry.size2 = (user_req.size == SIZE_TWO);
		push_entry.addr = user_req.addr;
		push_entry.data0 = user_req.wdata;
		push_entry.be0 = user_req.user_byte_enables;
		push_entry.data1 = '0;
		push_entry.be1 = '0;
		// the cycle after a two-word write carries its second beat
		beat2_nxt = acc & user_req.write_req & push_entry.size2;
		cnt_nxt = q_count + QC_W'(acc) - QC_W'(pop);
		ready_nxt = (cnt_nxt < QC_FULL) & ~beat2_nxt;
	end

	// -------------------------------------------------------------
	// refresh interval timer
	// -------------------------------------------------------------
	assign refresh_due = user_refresh_ctl_en ? user_refresh_req : refi_due_r;
	assign hit = open_r & (row_key(head.addr) == open_row_r);
	assign busy = (rec_r != '0) | (phy_wdata_valid_r != DV_NONE) |
		(phy_doing_read_r != DV_NONE) | (|rp_r) | wp_r[1].vld |
		wp_r[2].vld | wp_r[W_TOP].vld;

	always_comb begin
		refi_nxt = refi_r + REFI_W'(1);
		refi_due_nxt = refi_due_r;
		// self-refresh keeps the array alive, so the timer sleeps
		// entry clears it too, so no due flag is carried into self-refresh
		if (user_selfrefresh_ack_r || cmd_nxt.cmd == CMD_REF ||
			cmd_nxt.cmd == CMD_SRE) begin
			refi_nxt = '0;
			refi_due_nxt = 1'b0;
		end else if (refi_r == REFI_W'(REFI_CYC)) begin
			refi_nxt = refi_r;
			refi_due_nxt = 1'b1;
		end
		rec_nxt = rec_r;
		if (phy_wdata_valid_r != DV_NONE) begin
			rec_nxt = WAIT_W'(WR_CYC);
		end else if (rec_r != '0) begin
			rec_nxt = rec_r - WAIT_ONE;
		end
	end

	// -------------------------------------------------------------
	// command sequencer
	// -------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		ret_nxt = ret_r;
		wait_nxt = wait_r;
		cmd_nxt.cmd = CMD_NOP;
		cmd_nxt.bank = '0;
		cmd_nxt.addr = '0;
		cmd_nxt.bl = '0;
		cmd_nxt.cke = phy_cmd_r.cke;
		open_nxt = open_r;
		open_row_nxt = open_row_r;
		last_wr_nxt = last_wr_r;
		pop = 1'b0;
		ins_wr = 1'b0;
		ins_rd = 1'b0;
		ref_ack_nxt = 1'b0;
		pd_ack_nxt = user_powerdown_ack_r;
		sr_ack_nxt = user_selfrefresh_ack_r;
		case (st_r)
		S_IDLE: begin
			if (refresh_due) begin
				st_nxt = open_r ? S_PRE : S_REF;
				ret_nxt = S_REF;
			end else if (user_powerdown_req) begin
				st_nxt = open_r ? S_PRE : S_PDE;
				ret_nxt = S_PDE;
			end else if (user_selfrefresh_req) begin
				st_nxt = open_r ? S_PRE : S_SRE;
				ret_nxt = S_SRE;
			end else if (q_count != QC_ZERO) begin
				if (!open_r) begin
					st_nxt = S_ACT;
				end else if (!hit) begin
					st_nxt = S_PRE;
					ret_nxt = S_IDLE;
				end else if (head.is_wr == last_wr_r || !busy) begin
					// direction turns wait for the data bus to drain
					st_nxt = S_CMD;
				end
			end
		end
		S_ACT: begin
			cmd_nxt.cmd = CMD_ACT;
			cmd_nxt.bank = bank_of(head.addr);
			cmd_nxt.addr = head.addr[COL_W +: ROW_W];
			open_nxt = 1'b1;
			open_row_nxt = row_key(head.addr);
			wait_nxt = WAIT_W'(RCD_CYC);
			ret_nxt = S_CMD;
			st_nxt = S_WAIT;
		end
		S_CMD: begin
			cmd_nxt.cmd = head.is_wr ? CMD_WR : CMD_RD;
			cmd_nxt.bank = bank_of(head.addr);
			cmd_nxt.addr = MA_W'({head.addr[COL_W-1:0], COL_PAD});
			cmd_nxt.bl = head.size2 ? MEM_BL8 : MEM_BL4;
			pop = 1'b1;
			ins_wr = head.is_wr;
			ins_rd = ~head.is_wr;
			last_wr_nxt = head.is_wr;
			st_nxt = S_IDLE;
		end
		S_PRE: begin
			// write recovery and read drain before closing the row
			if (!busy) begin
				cmd_nxt.cmd = CMD_PRE;
				cmd_nxt.addr = MA_PRE_ALL;
				open_nxt = 1'b0;
				wait_nxt = WAIT_W'(RP_CYC);
				st_nxt = S_WAIT;
			end
		end
		S_REF: begin
			cmd_nxt.cmd = CMD_REF;
			ref_ack_nxt = 1'b1;
			wait_nxt = WAIT_W'(RFC_CYC);
			ret_nxt = (user_powerdown_ack_r && user_powerdown_req) ?
				S_PDE : S_IDLE;
			st_nxt = S_WAIT;
		end
		S_PDE: begin
			cmd_nxt.cmd = CMD_PDE;
			cmd_nxt.cke = 1'b0;
			pd_ack_nxt = 1'b1;
			st_nxt = S_PD;
		end
		S_PD: begin
			if (!user_powerdown_req) begin
				st_nxt = S_PDX;
				ret_nxt = S_IDLE;
			end else if (refresh_due) begin
				st_nxt = S_PDX;
				ret_nxt = S_REF;
			end
		end
		S_PDX: begin
			cmd_nxt.cmd = CMD_PDX;
			cmd_nxt.cke = 1'b1;
			wait_nxt = WAIT_W'(XP_CYC);
			st_nxt = S_WAIT;
		end
		S_SRE: begin
			cmd_nxt.cmd = CMD_SRE;
			cmd_nxt.cke = 1'b0;
			sr_ack_nxt = 1'b1;
			st_nxt = S_SR;
		end
		S_SR: begin
			// no refresh is raised here at all
			if (!user_selfrefresh_req) begin
				st_nxt = S_SRX;
			end
		end
		S_SRX: begin
			cmd_nxt.cmd = CMD_SRX;
			cmd_nxt.cke = 1'b1;
			wait_nxt = WAIT_W'(XS_CYC);
			ret_nxt = S_IDLE;
			st_nxt = S_WAIT;
		end
		S_WAIT: begin
			wait_nxt = wait_r - WAIT_ONE;
			if (wait_r == WAIT_ONE) begin
				st_nxt = ret_r;
				// acks fall only once the exit time has passed
				if (ret_r == S_IDLE) begin
					pd_ack_nxt = 1'b0;
					sr_ack_nxt = 1'b0;
				end
			end
		end
		default: begin
			st_nxt = S_IDLE;
		end
		endcase
	end

	// -------------------------------------------------------------
	// write and read timing pipes
	// -------------------------------------------------------------
	for (genvar g = 1; g <= W_TOP; g++) begin : g_wshift
		if (g == W_TOP) begin : g_top
			assign wp_shift[g] = '0;
		end else begin : g_mid
			assign wp_shift[g] = wp_r[g + 1];
		end
	end

	always_comb begin
		wp_nxt = wp_shift;
		rp_nxt = {1'b0, rp_r[R_TOP:2]};
		if (ins_wr) begin
			wp_nxt[WL_CYC] = {1'b1, head.data0, head.be0};
			if (head.size2) begin
				wp_nxt[W_TOP] = {1'b1, head.data1, head.be1};
			end
		end
		if (ins_rd) begin
			rp_nxt[RL_CYC] = 1'b1;
			rp_nxt[R_TOP] = head.size2;
		end
		// low half goes out in the first full-rate clock of the cycle
		wvld_nxt = wp_r[1].vld ? DV_BOTH : DV_NONE;
		wdata_nxt = wp_r[1].vld ? wp_r[1].data : '0;
		mask_nxt = wp_r[1].vld ? ~wp_r[1].be : MASK_ALL;
		// strobe opens one full-rate clock early for the preamble
		dqs_nxt = wp_r[1].vld ? DV_BOTH :
			(wp_r[2].vld ? DQS_PRE : DV_NONE);
		drd_nxt = rp_r[1] ? DV_BOTH : DV_NONE;
	end

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= S_IDLE;
			ret_r <= S_IDLE;
			wait_r <= '0;
			rec_r <= '0;
			open_r <= 1'b0;
			open_row_r <= '0;
			last_wr_r <= 1'b0;
			beat2_r <= 1'b0;
			refi_r <= '0;
			refi_due_r <= 1'b0;
			wp_r <= '{default: '0};
			rp_r <= '0;
			user_ready_r <= 1'b0;
			user_rdata_r <= '0;
			user_rdata_valid_r <= 1'b0;
			user_refresh_ack_r <= 1'b0;
			user_powerdown_ack_r <= 1'b0;
			user_selfrefresh_ack_r <= 1'b0;
			phy_cmd_r <= '{CMD_NOP, '0, '0, '0, CKE_RST};
			phy_wdata_r <= '0;
			phy_write_mask_r <= MASK_ALL;
			phy_wdata_valid_r <= DV_NONE;
			phy_dqs_burst_r <= DV_NONE;
			phy_doing_read_r <= DV_NONE;
		end else begin
			st_r <= st_nxt;
			ret_r <= ret_nxt;
			wait_r <= wait_nxt;
			rec_r <= rec_nxt;
			open_r <= open_nxt;
			open_row_r <= open_row_nxt;
			last_wr_r <= last_wr_nxt;
			beat2_r <= beat2_nxt;
			refi_r <= refi_nxt;
			refi_due_r <= refi_due_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			user_ready_r <= ready_nxt;
			user_rdata_r <= phy_rdata;
			user_rdata_valid_r <= phy_rdata_valid;
			user_refresh_ack_r <= ref_ack_nxt;
			user_powerdown_ack_r <= pd_ack_nxt;
			user_selfrefresh_ack_r <= sr_ack_nxt;
			phy_cmd_r <= cmd_nxt;
			phy_wdata_r <= wdata_nxt;
			phy_write_mask_r <= mask_nxt;
			phy_wdata_valid_r <= wvld_nxt;
			phy_dqs_burst_r <= dqs_nxt;
			phy_doing_read_r <= drd_nxt;
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	localparam int WR_LAT = WL_CYC;
	localparam int RD_LAT = RL_CYC;

	sequence s_wr_cmd;
		phy_cmd_r.cmd == CMD_WR;
	endsequence
	sequence s_wr_data;
		phy_wdata_valid_r == DV_BOTH && phy_dqs_burst_r == DV_BOTH;
	endsequence
	sequence s_rd_cmd;
		phy_cmd_r.cmd == CMD_RD;
	endsequence

	a_wr_data_time: assert property (s_wr_cmd |-> ##WR_LAT s_wr_data)
		else $error("write data not presented on time");
	a_dqs_preamble: assert property (
		phy_wdata_valid_r == DV_BOTH && $past(phy_wdata_valid_r) == DV_NONE
		|-> $past(phy_dqs_burst_r) == DQS_PRE)
		else $error("strobe preamble missing");
	a_mask_idle: assert property (
		phy_wdata_valid_r == DV_NONE |-> phy_write_mask_r == MASK_ALL)
		else $error("mask open without write data");
	a_rd_capture: assert property (s_rd_cmd |-> ##RD_LAT
		phy_doing_read_r == DV_BOTH)
		else $error("read capture window late");
	a_ready_space: assert property (user_ready_r |-> q_count < QC_FULL)
		else $error("ready high with a full queue");
	a_ref_ack: assert property (
		user_refresh_ack_r == (phy_cmd_r.cmd == CMD_REF))
		else $error("refresh ack not paired with refresh");
	a_no_ref_sr: assert property (
		user_selfrefresh_ack_r |-> !user_refresh_ack_r && refi_due_r == 1'b0)
		else $error("refresh during self-refresh");
	a_pd_hold: assert property (
		user_powerdown_ack_r && user_powerdown_req |=> user_powerdown_ack_r)
		else $error("power-down ack dropped early");
	a_bl_map: assert property ((s_wr_cmd or s_rd_cmd) |->
		phy_cmd_r.bl == MEM_BL4 || phy_cmd_r.bl == MEM_BL8)
		else $error("bad memory burst length");
	a_ref_first: assert property (
		st_r == S_IDLE && refresh_due |=> st_r == S_PRE || st_r == S_REF)
		else $error("refresh not given priority");
	a_rd_return: assert property (phy_rdata_valid |=> user_rdata_valid_r)
		else $error("read data not returned");
endmodule : lrp_local_port

// ---- testbench/lrp_phy_model.sv ----
// phy-side stand-in that answers capture windows with numbered words
`timescale 1ns/10ps
module lrp_phy_model
	import lrp_pkg::*;
(
	input logic clk,
	input logic rst,
	input logic [1:0] doing_read,
	output logic [DATA_W-1:0] rdata,
	output logic rdata_valid
);
	logic [31:0] k_r;
	// --------------------------------------------------------------
	// read return
	// --------------------------------------------------------------
	// words are numbered so that any reordering shows at the user side
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			k_r <= 32'h0;
			rdata_valid <= 1'b0;
			rdata <= '0;
		end else if (doing_read == DV_BOTH) begin
			rdata_valid <= 1'b1;
			rdata <= {k_r, ~k_r};
			k_r <= k_r + 32'h1;
		end else begin
			rdata_valid <= 1'b0;
			// released bus: no stale word left standing
			rdata <= ~rdata;
		end
	end
endmodule : lrp_phy_model

// ---- testbench/lrp_local_port_bench.sv ----
// self-checking bench of the local request port
`timescale 1ns/10ps
module lrp_local_port_bench;
	import lrp_pkg::*;
	logic clk, rst, ctl_en, ref_req, pd_req, sr_req, pvld;
	lrp_user_req_t ureq;
	logic [DATA_W-1:0] prd, rdat, wdat;
	logic rdy, rvld, rack, pack, sack;
	lrp_phy_cmd_t pcmd;
	logic [BE_W-1:0] wmask;
	logic [1:0] wv, dqs, drd;
	int fail_count, checked, cyc, seed;
	logic [31:0] rk;
	logic [79:0] wq[$], rq[$], cq[$];
	lrp_local_port uut (.clk(clk), .rst(rst), .user_req(ureq),
		.user_refresh_ctl_en(ctl_en), .user_refresh_req(ref_req),
		.user_powerdown_req(pd_req), .user_selfrefresh_req(sr_req),
		.phy_rdata(prd), .phy_rdata_valid(pvld), .user_ready_r(rdy),
		.user_rdata_r(rdat), .user_rdata_valid_r(rvld),
		.user_refresh_ack_r(rack), .user_powerdown_ack_r(pack),
		.user_selfrefresh_ack_r(sack), .phy_cmd_r(pcmd),
		.phy_wdata_r(wdat), .phy_write_mask_r(wmask),
		.phy_wdata_valid_r(wv), .phy_dqs_burst_r(dqs),
		.phy_doing_read_r(drd));
	lrp_phy_model phy (.clk(clk), .rst(rst), .doing_read(drd),
		.rdata(prd), .rdata_valid(pvld));
	always #12.5 clk = ~clk;
	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic chk(input string nm, input logic [79:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// fields are held, not dropped, so back-to-back requests stay legal
	task automatic req(input logic wr, input logic [1:0] sz,
			input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] d;
		logic [BE_W-1:0] b;
		d = {$random(seed), $random(seed)};
		b = BE_W'($random(seed));
		ureq <= '{wr, !wr, 1'b1, sz, a, d, b};
		cq.push_back(80'({a[ADDR_W-1 -: BANK_W],
			MA_W'({a[COL_W-1:0], COL_PAD}),
			(sz == SIZE_TWO ? MEM_BL8 : MEM_BL4)}));
		if (wr)
			wq.push_back(80'({d, ~b}));
		for (int i = 0; i < 2; i++)
			if (!wr && (i == 0 || sz == SIZE_TWO)) begin
				rq.push_back(80'({rk, ~rk}));
				rk = rk + 32'h1;
			end
		do @(posedge clk); while (rdy !== 1'b1);
		if (wr && sz == SIZE_TWO) begin
			d = {$random(seed), $random(seed)};
			b = BE_W'($random(seed));
			ureq.write_req <= 1'b0;
			ureq.wdata <= d;
			ureq.user_byte_enables <= b;
			wq.push_back(80'({d, ~b}));
			@(posedge clk);
		end
	endtask : req
	task automatic idle(input int n);
		ureq.write_req <= 1'b0;
		ureq.read_req <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic lp(input logic sr);
		int n, r;
		r = 0;
		n = 0;
		if (sr) sr_req <= 1'b1; else pd_req <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while ((sr ? sack : pack) !== 1'b1 && n < 60);
		chk("lp_ack_on", 80'(sr ? sack : pack), 80'h1);
		repeat (400) begin
			@(posedge clk);
			if (rack === 1'b1) r++;
		end
		chk("lp_refresh", 80'(r > 0), 80'(!sr));
		sr_req <= 1'b0;
		pd_req <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((sr ? sack : pack) !== 1'b0 && n < 60);
		chk("lp_ack_off", 80'(sr ? sack : pack), 80'h0);
	endtask : lp
	// --------------------------------------------------------------
	// output watcher: oldest note against each result
	// --------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			complete_run;
		end
		if (!rst) begin
			if (rvld === 1'b1)
				chk("rdata", 80'(rdat), rq.pop_front());
			if (wv === DV_BOTH) begin
				chk("wdata", 80'({wdat, wmask}), wq.pop_front());
				chk("dqs", 80'(dqs), 80'(DV_BOTH));
			end
			if (pcmd.cmd == CMD_WR || pcmd.cmd == CMD_RD)
				chk("burst", 80'({pcmd.bank, pcmd.addr, pcmd.bl}),
					cq.pop_front());
			if (rack === 1'b1) begin
				chk("ref_cmd", 80'(pcmd.cmd), 80'(CMD_REF));
				chk("ref_in_sr", 80'(sack), 80'h0);
			end
		end
	end
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		int n;
		seed = 32'hc21e;
		clk = 1'b0;
		rst = 1'b1;
		ureq = '0;
		{ctl_en, ref_req, pd_req, sr_req} = 4'h0;
		fail_count = 0;
		checked = 0;
		cyc = 0;
		rk = 32'h0;
		repeat (6) @(posedge clk);
		chk("rst_ready", 80'({rdy, rvld, rack, pack, sack}), 80'h0);
		chk("rst_mask", 80'({pcmd.cmd, wmask}), 80'(MASK_ALL));
		rst <= 1'b0;
		@(posedge clk);
		req(1'b1, SIZE_TWO, 24'h0);
		req(1'b1, SIZE_TWO, 24'h2);
		req(1'b1, SIZE_TWO, 24'h4);
		req(1'b0, SIZE_TWO, 24'h0);
		req(1'b0, SIZE_TWO, 24'h2);
		req(1'b0, 2'h1, 24'h4);
		idle(60);
		for (int i = 0; i < 16; i++)
			req(1'($random(seed)), ($random(seed) & 1) ? SIZE_TWO : 2'h1,
				ADDR_W'($random(seed)) & 24'h6001fc);
		idle(100);
		ctl_en <= 1'b1;
		req(1'b0, 2'h1, 24'h8);
		ref_req <= 1'b1;
		idle(0);
		n = 0;
		for (int i = 0; i < 100 && n < 2; i++) begin
			@(posedge clk);
			if (rack === 1'b1) n++;
		end
		ref_req <= 1'b0;
		chk("ref_count", 80'(n), 80'h2);
		idle(40);
		// power-down under user refresh control: user keeps refreshing
		pd_req <= 1'b1;
		do @(posedge clk); while (pack !== 1'b1);
		chk("pd_cke", 80'(pcmd.cke), 80'h0);
		ref_req <= 1'b1;
		do @(posedge clk); while (rack !== 1'b1);
		ref_req <= 1'b0;
		chk("pd_ref_ack", 80'(pack), 80'h1);
		repeat (10) @(posedge clk);
		chk("pd_kept", 80'(pack), 80'h1);
		pd_req <= 1'b0;
		do @(posedge clk); while (pack !== 1'b0);
		ctl_en <= 1'b0;
		lp(1'b0);
		lp(1'b1);
		req(1'b1, 2'h1, 24'h20);
		req(1'b0, 2'h1, 24'h20);
		idle(60);
		chk("drained", 80'(wq.size() + rq.size() + cq.size()), 80'h0);
		complete_run;
	end
endmodule : lrp_local_port_bench
